// [pkg/mri_pkg.sv]
// Purpose: Constants for the receive/MAC interrupt mask and status block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
package mri_pkg;

    // ********************************
    // Widths
    // ********************************
    localparam int unsigned MRI_RX_CH = 8;
    localparam int unsigned MRI_MAC_SRC = 2;
    localparam int unsigned MRI_ADDR_W = 12;
    localparam int unsigned MRI_DATA_W = 32;

    // ********************************
    // Register byte offsets
    // ********************************
    localparam logic [MRI_ADDR_W-1:0] MRI_RX_IRQ_STATUS_RAW_OFS = 12'h000;
    localparam logic [MRI_ADDR_W-1:0] MRI_RX_IRQ_STATUS_MASKED_OFS = 12'h004;
    localparam logic [MRI_ADDR_W-1:0] MRI_RX_IRQ_ENABLE_SET_OFS = 12'h008;
    localparam logic [MRI_ADDR_W-1:0] MRI_RX_IRQ_ENABLE_CLEAR_OFS = 12'h00C;
    localparam logic [MRI_ADDR_W-1:0] MRI_MAC_IRQ_STATUS_RAW_OFS = 12'h010;
    localparam logic [MRI_ADDR_W-1:0] MRI_MAC_IRQ_STATUS_MASKED_OFS = 12'h014;
    localparam logic [MRI_ADDR_W-1:0] MRI_MAC_IRQ_ENABLE_SET_OFS = 12'h018;
    localparam logic [MRI_ADDR_W-1:0] MRI_MAC_IRQ_ENABLE_CLEAR_OFS = 12'h01C;

    // ********************************
    // MAC field positions
    // ********************************
    localparam int unsigned MRI_MAC_HOST_BIT = 1;
    localparam int unsigned MRI_MAC_STAT_BIT = 0;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [MRI_RX_CH-1:0] MRI_RX_RST = 8'h00;
    localparam logic [MRI_MAC_SRC-1:0] MRI_MAC_RST = 2'h0;
    localparam logic [MRI_DATA_W-1:0] MRI_DATA_RST = 32'h0000_0000;

endpackage

// [src/mri_irq_mask_status.sv]
// Purpose: Receive-channel and MAC-level interrupt status and mask registers.
// Assumes: Pending inputs are levels synchronous to clk_sys_i.
// Notes: APB slave, zero wait states while clk_en_i is high.
`timescale 1ns/100ps

module mri_irq_mask_status (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [mri_pkg::MRI_ADDR_W-1:0] paddr_i,
    input wire logic [mri_pkg::MRI_DATA_W-1:0] pwdata_i,
    output logic [mri_pkg::MRI_DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt sources
    input wire logic [mri_pkg::MRI_RX_CH-1:0] rx_channel_pending_i,
    input wire logic host_error_pending_i,
    input wire logic statistics_pending_i,
    // Combined request
    output logic irq_o
);
    import mri_pkg::*;

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic [MRI_RX_CH-1:0] rx_raw;
        logic [MRI_RX_CH-1:0] rx_en;
        logic [MRI_MAC_SRC-1:0] mac_raw;
        logic [MRI_MAC_SRC-1:0] mac_en;
        logic [MRI_DATA_W-1:0] rdata;
        logic slverr;
        logic rd_ready;
        logic irq;
    } mri_state_t;

    mri_state_t state_reg;
    mri_state_t state_next;

    logic [MRI_RX_CH-1:0] rx_masked;
    logic [MRI_MAC_SRC-1:0] mac_masked;
    logic [MRI_MAC_SRC-1:0] mac_src;
    logic [MRI_DATA_W-1:0] rd_mux;
    logic rd_hit;
    logic xfer_done;
    logic wr_done;

    // ********************************
    // Masked views
    // ********************************
    genvar ch;
    generate
        for (ch = 0; ch < MRI_RX_CH; ch++) begin : g_rx_mask
            assign rx_masked[ch] = state_reg.rx_raw[ch] & state_reg.rx_en[ch];
        end
    endgenerate

    assign mac_masked = state_reg.mac_raw & state_reg.mac_en;

    always_comb begin
        mac_src = MRI_MAC_RST;
        mac_src[MRI_MAC_HOST_BIT] = host_error_pending_i;
        mac_src[MRI_MAC_STAT_BIT] = statistics_pending_i;
    end

    // ********************************
    // Read decode
    // ********************************
    // Narrow fields zero-extended so upper bits always read zero
    always_comb begin
        rd_mux = MRI_DATA_RST;
        rd_hit = 1'b1;
        unique case (paddr_i)
            MRI_RX_IRQ_STATUS_RAW_OFS: begin
                rd_mux[MRI_RX_CH-1:0] = state_reg.rx_raw;
            end
            MRI_RX_IRQ_STATUS_MASKED_OFS: begin
                rd_mux[MRI_RX_CH-1:0] = rx_masked;
            end
            MRI_RX_IRQ_ENABLE_SET_OFS, MRI_RX_IRQ_ENABLE_CLEAR_OFS: begin
                rd_mux[MRI_RX_CH-1:0] = state_reg.rx_en;
            end
            MRI_MAC_IRQ_STATUS_RAW_OFS: begin
                rd_mux[MRI_MAC_SRC-1:0] = state_reg.mac_raw;
            end
            MRI_MAC_IRQ_STATUS_MASKED_OFS: begin
                rd_mux[MRI_MAC_SRC-1:0] = mac_masked;
            end
            MRI_MAC_IRQ_ENABLE_SET_OFS, MRI_MAC_IRQ_ENABLE_CLEAR_OFS: begin
                rd_mux[MRI_MAC_SRC-1:0] = state_reg.mac_en;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read data is captured before the access completes so prdata is a flop
    assign pready_o = clk_en_i & state_reg.rd_ready;
    assign xfer_done = psel_i & penable_i & pready_o;
    assign wr_done = xfer_done & pwrite_i & rd_hit;

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        state_next = state_reg;
        state_next.rx_raw = rx_channel_pending_i;
        state_next.mac_raw = mac_src;
        if (psel_i && !state_reg.rd_ready) begin
            state_next.rdata = rd_mux;
            state_next.slverr = ~rd_hit;
            state_next.rd_ready = 1'b1;
        end
        if (xfer_done) begin
            state_next.rd_ready = 1'b0;
        end
        // Writes to status offsets fall through untouched
        if (wr_done) begin
            unique case (paddr_i)
                MRI_RX_IRQ_ENABLE_SET_OFS: begin
                    state_next.rx_en = state_reg.rx_en | pwdata_i[MRI_RX_CH-1:0];
                end
                MRI_RX_IRQ_ENABLE_CLEAR_OFS: begin
                    state_next.rx_en = state_reg.rx_en & ~pwdata_i[MRI_RX_CH-1:0];
                end
                MRI_MAC_IRQ_ENABLE_SET_OFS: begin
                    state_next.mac_en = state_reg.mac_en | pwdata_i[MRI_MAC_SRC-1:0];
                end
                MRI_MAC_IRQ_ENABLE_CLEAR_OFS: begin
                    state_next.mac_en = state_reg.mac_en & ~pwdata_i[MRI_MAC_SRC-1:0];
                end
                default: begin
                    state_next.mac_en = state_reg.mac_en;
                end
            endcase
        end
        state_next.irq = (|(state_next.rx_raw & state_next.rx_en))
                       | (|(state_next.mac_raw & state_next.mac_en));
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state_reg.rx_raw <= MRI_RX_RST;
            state_reg.rx_en <= MRI_RX_RST;
            state_reg.mac_raw <= MRI_MAC_RST;
            state_reg.mac_en <= MRI_MAC_RST;
            state_reg.rdata <= MRI_DATA_RST;
            state_reg.slverr <= 1'b0;
            state_reg.rd_ready <= 1'b0;
            state_reg.irq <= 1'b0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    assign prdata_o = state_reg.rdata;
    assign pslverr_o = state_reg.slverr;
    assign irq_o = state_reg.irq;

endmodule // mri_irq_mask_status

// [dv/mri_props.sv]
// Purpose: Port-level checks of the interrupt mask and status block.
// Assumes: Zero wait states while clk_en_i is high; bench keeps clk_en_i high in reset.
// Notes: Status read values are only checked while every source is idle.
`timescale 1ns/100ps
module mri_props (
    // Clock, reset, APB, sources
    input wire logic clk_sys_i, rst_b_i, clk_en_i, psel_i, penable_i, pwrite_i, pready_o,
    input wire logic pslverr_o, irq_o, host_error_pending_i, statistics_pending_i,
    input wire logic [mri_pkg::MRI_ADDR_W-1:0] paddr_i,
    input wire logic [mri_pkg::MRI_DATA_W-1:0] pwdata_i, prdata_o,
    input wire logic [mri_pkg::MRI_RX_CH-1:0] rx_channel_pending_i
);
    import mri_pkg::*;
    logic acc, map, zin, z1, z2;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    assign acc = psel_i && penable_i && pready_o;
    assign map = paddr_i[11:5] == 7'h00 && paddr_i[1:0] == 2'h0;
    assign zin = rx_channel_pending_i == 8'h00 && !host_error_pending_i && !statistics_pending_i;
    // Tracks raw capture, then read capture: two enabled edges behind the pins
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) {z1, z2} <= 2'h3;
        else if (clk_en_i) {z1, z2} <= {zin, z1};
    end
    property p_irq_idle; $past(clk_en_i && zin) |-> !irq_o; endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq_o high, no source");
    property p_irq_frozen; !clk_en_i |=> $stable(irq_o); endproperty
    a_irq_frozen: assert property (p_irq_frozen) else $error("irq_o moved, frozen");
    property p_rx_upper; acc && !pwrite_i && paddr_i[11:4] == 8'h00 |-> prdata_o[31:8] == 0; endproperty
    a_rx_upper: assert property (p_rx_upper) else $error("rx upper bits set");
    property p_mac_upper; acc && !pwrite_i && paddr_i[11:4] == 8'h01 |-> prdata_o[31:2] == 0; endproperty
    a_mac_upper: assert property (p_mac_upper) else $error("mac upper bits set");
    property p_err_zero; acc && pslverr_o |-> prdata_o == 32'h0000_0000; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    property p_err_unmap; acc && !map |-> pslverr_o; endproperty
    a_err_unmap: assert property (p_err_unmap) else $error("unmapped without error");
    property p_ok_map; acc && map |-> !pslverr_o; endproperty
    a_ok_map: assert property (p_ok_map) else $error("mapped with error");
    property p_stat_idle; acc && !pwrite_i && map && !paddr_i[3] && z2 |-> prdata_o == 0; endproperty
    a_stat_idle: assert property (p_stat_idle) else $error("status set, no source");
endmodule // mri_props

bind mri_irq_mask_status mri_props u_props (.*);

// [dv/testbench.sv]
// Purpose: Random register and source traffic with a reference model.
// Assumes: Sources held steady while a transfer is in flight.
// Notes: clk_en_i is dropped at random setup edges to stretch transfers.
`timescale 1ns/100ps
module testbench;
    import mri_pkg::*;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, clk_en_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o, irq_o;
    logic host_error_pending_i = 1'b0, statistics_pending_i = 1'b0;
    logic [MRI_ADDR_W-1:0] paddr_i = 12'h000;
    logic [MRI_DATA_W-1:0] pwdata_i = 32'h0000_0000, prdata_o;
    logic [MRI_RX_CH-1:0] rx_channel_pending_i = 8'h00, rx_en = 8'h00;
    logic [1:0] mac_en = 2'h0;
    int n_fail = 0, checked = 0;
    mri_irq_mask_status dut (.*);
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task conclude;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    function logic [31:0] exp_rd(input logic [11:0] a);
        logic [1:0] m;
        m = {host_error_pending_i, statistics_pending_i};
        case (a)
            12'h000: exp_rd = 32'(rx_channel_pending_i);
            12'h004: exp_rd = 32'(rx_channel_pending_i & rx_en);
            12'h008, 12'h00C: exp_rd = 32'(rx_en);
            12'h010: exp_rd = 32'(m);
            12'h014: exp_rd = 32'(m & mac_en);
            12'h018, 12'h01C: exp_rd = 32'(mac_en);
            default: exp_rd = 32'h0000_0000;
        endcase
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        logic rdy;
        logic [31:0] ex, rd, er;
        ex = exp_rd(a);
        n = 0;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        clk_en_i <= ($urandom % 4 != 0);
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        clk_en_i <= 1'b1;
        // Answer is sampled mid-cycle, where pready_o and read data have settled
        do begin
            @(negedge clk_sys_i);
            n++;
            rdy = (pready_o === 1'b1);
            rd = prdata_o;
            er = 32'(pslverr_o);
            @(posedge clk_sys_i);
        end while (!rdy && n < 20);
        if (n >= 20) begin
            n_fail++;
            conclude();
        end
        cmp("pslverr", 32'(!(a[11:5] == 7'h00 && a[1:0] == 2'h0)), er);
        if (!w) cmp("prdata", ex, rd);
        case (w ? a : 12'hFFF)
            12'h008: rx_en = rx_en | d[7:0];
            12'h00C: rx_en = rx_en & ~d[7:0];
            12'h018: mac_en = mac_en | d[1:0];
            12'h01C: mac_en = mac_en & ~d[1:0];
            default: ;
        endcase
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    initial begin
        logic [11:0] a;
        void'($urandom(49));
        repeat (16) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            // Every fifth pass all sources idle, so idle status and irq are exercised
            rx_channel_pending_i <= (i % 5 == 2) ? 8'h00 : (i < 8) ? 8'hFF : 8'($urandom);
            host_error_pending_i <= (i % 5 != 2) & ((i < 8) | 1'($urandom));
            statistics_pending_i <= (i % 5 != 2) & ((i < 8) | 1'($urandom));
            repeat (2) @(posedge clk_sys_i);
            cmp("irq", 32'(|(rx_channel_pending_i & rx_en) ||
                |({host_error_pending_i, statistics_pending_i} & mac_en)), 32'(irq_o));
            // Early passes read every register back from reset first
            a = (i % 10 == 9) ? 12'h104 : 12'(4 * ((i < 8) ? i : $urandom % 8));
            apb((i < 8) ? 1'b0 : 1'($urandom), a, (i % 7 == 3) ? 32'h0000_0000 : $urandom);
        end
        conclude();
    end
endmodule // testbench
